// ==== bit_timer.sv ====
// Bit-period timer that issues one-cycle ticks at the learned rate.
`timescale 1ns/100ps
module bit_timer #(
  parameter int unsigned W = debug_wire_pkg::CNT_W
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  // Controller side
  bit_timer_if.timer bt
);

  typedef struct packed {
    logic         run;
    logic [W-1:0] cnt;
  } timer_state_t;

  timer_state_t state_reg;
  timer_state_t state_next;

  // Tick is a handshake pulse, so it is decoded straight from the count.
  assign bt.tick = state_reg.run && (state_reg.cnt == '0);

  // Load wins over halt and over the running count, so a restart is never
  // lost when it coincides with the end of an interval.
  always_comb begin
    state_next = state_reg;
    if (bt.load) begin
      state_next.run = 1'b1;
      state_next.cnt = bt.half ? (W'(bt.period >> 1) - W'(1))
                               : (bt.period - W'(1));
    end else if (bt.halt) begin
      state_next.run = 1'b0;
    end else if (state_reg.run) begin
      state_next.cnt = (state_reg.cnt == '0) ? (bt.period - W'(1))
                                             : (state_reg.cnt - W'(1));
    end
  end

  // State register.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule : bit_timer

// ==== bit_timer_if.sv ====
// Control and tick signals between the link controller and its bit timer.
`timescale 1ns/100ps
interface bit_timer_if #(
  parameter int unsigned W = debug_wire_pkg::CNT_W
);
  logic [W-1:0] period;  // Bit period in system clocks.
  logic         load;    // Restart the timer this cycle.
  logic         half;    // With load: first interval is half a period.
  logic         halt;    // Stop the timer.
  logic         tick;    // One-cycle pulse at the end of each interval.

  modport ctrl  (output period, output load, output half, output halt,
                 input tick);
  modport timer (input period, input load, input half, input halt,
                 output tick);
endinterface : bit_timer_if

// ==== debug_wire_autobaud_link.sv ====
// Single-wire half-duplex debug link with rate detector and generator.
`timescale 1ns/100ps

// How it works
// - Reply may start as soon as the incoming stop bit is sampled.
// - After reset nothing is sent until host data has arrived.
// - Sync low run counts as eight bits: start plus seven zeros.
// - Rate detector and generator adapt to any host rate of 4 to 8191 clocks per bit.
// - Frame: low start, eight data bits LSB first, high stop.
module debug_wire_autobaud_link #(
  parameter int unsigned CNT_W = debug_wire_pkg::CNT_W
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  // Debug line pin
  input  wire logic       debug_line_pin_i,
  output logic            debug_line_pin_o,
  output logic            debug_line_pin_oe_o,
  // Received characters toward the debug unit
  output logic [7:0]      rx_data_o,
  output logic            rx_valid_o,
  output logic            rx_frame_err_o,
  // Characters to send from the debug unit
  input  wire logic [7:0] tx_data_i,
  input  wire logic       tx_valid_i,
  output logic            tx_ready_o,
  // Link status
  output logic            rate_locked_o
);

  ////////////////////////////////////////////////////////////////////////
  // Types and state

  typedef enum logic [3:0] {
    SYNC_WAIT_LOW, SYNC_MEASURE, SYNC_TAIL, IDLE,
    RX_START, RX_DATA, RX_STOP, RX_WAIT_HIGH,
    TX_START, TX_DATA, TX_STOP
  } link_mode_t;

  typedef struct packed {
    logic             sync1;
    logic             sync2;
    link_mode_t       mode;
    logic [CNT_W-1:0] meas;
    logic [CNT_W-1:0] period;
    logic [2:0]       bit_idx;
    logic [7:0]       shreg;
    logic [7:0]       rx_data;
    logic             rx_valid;
    logic             rx_err;
    logic             line_out;
    logic             locked;
  } link_state_t;

  link_state_t state_reg;
  link_state_t state_next;

  bit_timer_if #(.W(CNT_W)) bt ();

  bit_timer #(.W(CNT_W)) u_bit_timer (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .bt       (bt)
  );

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  // The pin is only driven while a character of ours is on the wire.
  assign debug_line_pin_o    = state_reg.line_out;
  assign debug_line_pin_oe_o = (state_reg.mode == TX_START) ||
                               (state_reg.mode == TX_DATA)  ||
                               (state_reg.mode == TX_STOP);
  assign rx_data_o           = state_reg.rx_data;
  assign rx_valid_o          = state_reg.rx_valid;
  assign rx_frame_err_o      = state_reg.rx_err;
  assign rate_locked_o       = state_reg.locked;
  // Sending is offered only once the rate is known and the line is quiet.
  // no early send
  assign tx_ready_o = (state_reg.mode == IDLE) && state_reg.sync2;
  assign bt.period  = state_reg.period;

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    state_next          = state_reg;
    state_next.sync1    = debug_line_pin_i;
    state_next.sync2    = state_reg.sync1;
    state_next.rx_valid = 1'b0;
    state_next.rx_err   = 1'b0;
    bt.load             = 1'b0;
    bt.half             = 1'b0;
    bt.halt             = 1'b0;

    unique case (state_reg.mode)
      SYNC_WAIT_LOW: begin
        if (!state_reg.sync2) begin
          state_next.mode = SYNC_MEASURE;
          state_next.meas = CNT_W'(1);
        end
      end
      SYNC_MEASURE: begin
        if (!state_reg.sync2) begin
          // A low run longer than the counter is a break, not a sync.
          if (&state_reg.meas) begin
            state_next.mode = SYNC_WAIT_LOW;
          end else begin
            state_next.meas = state_reg.meas + CNT_W'(1);
          end
        end else if ((state_reg.meas >> debug_wire_pkg::SYNC_SHIFT) <
                     CNT_W'(debug_wire_pkg::MIN_PERIOD)) begin
          // Too short to time reliably: treat it as a glitch.
          state_next.mode = SYNC_WAIT_LOW;
        end else begin
          state_next.period  = state_reg.meas >> debug_wire_pkg::SYNC_SHIFT;
          state_next.mode    = SYNC_TAIL;
          state_next.bit_idx = '0;
          bt.load            = 1'b1;
        end
      end
      // D7 and stop must stay high; a low here means a bad sync character.
      SYNC_TAIL: begin
        if (!state_reg.sync2) begin
          bt.halt         = 1'b1;
          state_next.mode = SYNC_WAIT_LOW;
        end else if (bt.tick) begin
          state_next.bit_idx = state_reg.bit_idx + 3'h1;
          if (state_reg.bit_idx + 3'h1 == debug_wire_pkg::SYNC_TAIL_BITS)
          begin
            bt.halt           = 1'b1;
            state_next.mode   = IDLE;
            state_next.locked = 1'b1;
          end
        end
      end
      // Incoming start bit has priority over a pending send.
      IDLE: begin
        if (!state_reg.sync2) begin
          state_next.mode = RX_START;
          bt.load         = 1'b1;
          bt.half         = 1'b1;
        end else if (tx_valid_i) begin
          state_next.mode     = TX_START;
          state_next.shreg    = tx_data_i;
          state_next.line_out = 1'b0;
          bt.load             = 1'b1;
        end
      end
      // Mid start bit: a high here was only a glitch.
      RX_START: begin
        if (bt.tick) begin
          if (!state_reg.sync2) begin
            state_next.mode    = RX_DATA;
            state_next.bit_idx = '0;
          end else begin
            bt.halt         = 1'b1;
            state_next.mode = IDLE;
          end
        end
      end
      RX_DATA: begin
        if (bt.tick) begin
          state_next.shreg = {state_reg.sync2, state_reg.shreg[7:1]};
          if (state_reg.bit_idx == debug_wire_pkg::LAST_DATA_BIT) begin
            state_next.mode = RX_STOP;
          end else begin
            state_next.bit_idx = state_reg.bit_idx + 3'h1;
          end
        end
      end
      // Stop is sampled mid-bit; the line is free for a reply right after.
      // turnaround at stop
      RX_STOP: begin
        if (bt.tick) begin
          bt.halt = 1'b1;
          if (state_reg.sync2) begin
            state_next.rx_data  = state_reg.shreg;
            state_next.rx_valid = 1'b1;
            state_next.mode     = IDLE;
          end else begin
            state_next.rx_err = 1'b1;
            state_next.mode   = RX_WAIT_HIGH;
          end
        end
      end
      // After a framing error, wait for the line to go back high.
      RX_WAIT_HIGH: begin
        if (state_reg.sync2) begin
          state_next.mode = IDLE;
        end
      end
      TX_START: begin
        if (bt.tick) begin
          state_next.line_out = state_reg.shreg[0];
          state_next.shreg    = state_reg.shreg >> 1;
          state_next.bit_idx  = '0;
          state_next.mode     = TX_DATA;
        end
      end
      TX_DATA: begin
        if (bt.tick) begin
          if (state_reg.bit_idx == debug_wire_pkg::LAST_DATA_BIT) begin
            state_next.line_out = 1'b1;
            state_next.mode     = TX_STOP;
          end else begin
            state_next.line_out = state_reg.shreg[0];
            state_next.shreg    = state_reg.shreg >> 1;
            state_next.bit_idx  = state_reg.bit_idx + 3'h1;
          end
        end
      end
      TX_STOP: begin
        if (bt.tick) begin
          bt.halt         = 1'b1;
          state_next.mode = IDLE;
        end
      end
      default: begin
        state_next.mode = SYNC_WAIT_LOW;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // State register

  // The synchroniser resets to the idle line level so no false start shows.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg          <= '0;
      state_reg.sync1    <= debug_wire_pkg::LINE_IDLE;
      state_reg.sync2    <= debug_wire_pkg::LINE_IDLE;
      state_reg.line_out <= debug_wire_pkg::LINE_IDLE;
      state_reg.mode     <= SYNC_WAIT_LOW;
      state_reg.rx_data  <= debug_wire_pkg::DATA_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule : debug_wire_autobaud_link

// ==== debug_wire_autobaud_link_properties.sv ====
// Concurrent checks on the debug link's top-level ports.
`timescale 1ns/100ps
module debug_wire_autobaud_link_properties #(
  parameter int BIT_P = 8
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  // Watched ports
  input  wire logic debug_line_pin_o,
  input  wire logic debug_line_pin_oe_o,
  input  wire logic rx_valid_o,
  input  wire logic rx_frame_err_o,
  input  wire logic tx_valid_i,
  input  wire logic tx_ready_o,
  input  wire logic rate_locked_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  int unsigned oe_cnt;
  //////////////////////////////////////////////////////////////////////////
  // Counts the cycles of one drive, so frame length is checked exactly.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      oe_cnt <= 0;
    end else begin
      oe_cnt <= debug_line_pin_oe_o ? oe_cnt + 1 : 0;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // Silent until locked.
  property p_quiet;
    !rate_locked_o |-> !debug_line_pin_oe_o && !tx_ready_o;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("line driven before lock");
  property p_lock;
    rate_locked_o |=> rate_locked_o;
  endproperty
  a_lock: assert property (p_lock)
    else $error("lock dropped");
  property p_start;
    tx_valid_i && tx_ready_o |=> debug_line_pin_oe_o && !debug_line_pin_o;
  endproperty
  a_start: assert property (p_start)
    else $error("no start bit after request");
  property p_stop;
    $fell(debug_line_pin_oe_o) |-> $past(debug_line_pin_o);
  endproperty
  a_stop: assert property (p_stop)
    else $error("last bit of frame not high");
  property p_len;
    $fell(debug_line_pin_oe_o) |-> oe_cnt == 10 * BIT_P;
  endproperty
  a_len: assert property (p_len)
    else $error("frame length wrong");
  property p_busy;
    debug_line_pin_oe_o |-> !tx_ready_o;
  endproperty
  a_busy: assert property (p_busy)
    else $error("ready while sending");
  property p_rx;
    rx_valid_o |-> !rx_frame_err_o ##1 !rx_valid_o;
  endproperty
  a_rx: assert property (p_rx)
    else $error("bad receive pulse");
endmodule : debug_wire_autobaud_link_properties

// ==== debug_wire_autobaud_link_tb_top.sv ====
// Self-checking bench for the single-wire debug link.
`timescale 1ns/100ps
module debug_wire_autobaud_link_tb_top;
  localparam int P = 8;
  logic       clk_i    = 1'b0;
  logic       arst_n_i = 1'b0;
  logic       tx_valid = 1'b0;
  logic [7:0] tx_data  = 8'h00;
  logic       host_low, line, pin, oe, rxv, err, rdy, lck;
  logic [7:0] rx_data;
  int         failures    = 0;
  int         checks_done = 0;
  int         k;
  // Clock at 40 MHz.
  always #12.5 clk_i = ~clk_i;
  // Pulled-up wire; either party may pull it low.
  assign line = ~host_low & ~(oe & ~pin);
  host_model host_model_i (.clk_i(clk_i), .pull_low_o(host_low));
  debug_wire_autobaud_link debug_wire_autobaud_link_i (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .debug_line_pin_i(line),
    .debug_line_pin_o(pin), .debug_line_pin_oe_o(oe),
    .rx_data_o(rx_data), .rx_valid_o(rxv), .rx_frame_err_o(err),
    .tx_data_i(tx_data), .tx_valid_i(tx_valid), .tx_ready_o(rdy),
    .rate_locked_o(lck));
  //////////////////////////////////////////////////////////////////////////
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask : step
  task automatic cmp(input string n, input logic [7:0] e,
                     input logic [7:0] s);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : cmp
  task automatic end_of_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test
  //////////////////////////////////////////////////////////////////////////
  // A send request before any host data must stay unanswered.
  task automatic t_idle();
    logic s;
    s = 1'b0;
    tx_valid = 1'b1;
    tx_data  = 8'h55;
    for (k = 0; k < 60; k++) begin
      step(1);
      s = s | oe | rdy | lck;
    end
    tx_valid = 1'b0;
    cmp("quiet", 8'h00, {7'h0, s});
  endtask : t_idle
  // Too fast a sync is ignored; a proper one locks the rate.
  task automatic t_sync();
    host_model_i.send(8'h80, 3, 1'b1);
    step(10);
    cmp("lock_short", 8'h00, {7'h0, lck});
    // A high D6 followed by a low D7 must spoil the high tail.
    host_model_i.send(8'h40, P, 1'b1);
    step(10);
    cmp("lock_tail", 8'h00, {7'h0, lck});
    host_model_i.send(8'h80, P, 1'b1);
    for (k = 0; k < 4 * P && lck !== 1'b1; k++) step(1);
    cmp("lock", 8'h01, {7'h0, lck});
  endtask : t_sync
  // Receive a byte, then reply as soon as the host stop bit is sampled mid-bit.
  task automatic t_echo();
    logic [9:0] got;
    fork
      host_model_i.send(8'hA5, P, 1'b1);
      begin
        for (k = 0; k < 11 * P && rxv !== 1'b1; k++) step(1);
        step(1);
        cmp("rx_data", 8'hA5, rx_data);
        tx_data  = 8'h3C;
        tx_valid = 1'b1;
        for (k = 0; k < 4 && oe !== 1'b1; k++) step(1);
        tx_valid = 1'b0;
        cmp("reply", 8'h01, {7'h0, oe});
        step(P / 2);
        for (k = 0; k < 10; k++) begin
          got[k] = pin;
          step(P);
        end
      end
    join
    cmp("tx_bits", 8'h3C, got[8:1]);
    cmp("tx_frame", 8'h02, {6'h0, got[9], got[0]});
    cmp("ready_back", 8'h01, {7'h0, rdy});
  endtask : t_echo
  // A low stop bit gives an error and no byte.
  task automatic t_err();
    logic e;
    logic v;
    e = 1'b0;
    v = 1'b0;
    fork
      host_model_i.send(8'h5A, P, 1'b0);
      for (k = 0; k < 12 * P; k++) begin
        step(1);
        e = e | err;
        v = v | rxv;
      end
    join
    cmp("err_flags", 8'h02, {6'h0, e, v});
  endtask : t_err
  // A short low pulse is dropped at the start-bit midpoint.
  task automatic t_glitch();
    logic e;
    logic v;
    e = 1'b0;
    v = 1'b0;
    fork
      host_model_i.pulse(2);
      for (k = 0; k < 3 * P; k++) begin
        step(1);
        e = e | err;
        v = v | rxv;
      end
    join
    cmp("glitch_flags", 8'h00, {6'h0, e, v});
    cmp("glitch_ready", 8'h01, {7'h0, rdy});
  endtask : t_glitch
  // A reset in mid-run forgets the rate and silences the link again.
  task automatic t_reset();
    arst_n_i = 1'b0;
    step(2);
    arst_n_i = 1'b1;
    step(2);
    cmp("reset_quiet", 8'h00, {5'h0, lck, rdy, oe});
  endtask : t_reset
  //////////////////////////////////////////////////////////////////////////
  // Main sequence after four reset cycles.
  initial begin
    step(4);
    arst_n_i = 1'b1;
    t_idle();
    t_sync();
    t_echo();
    t_err();
    t_glitch();
    t_reset();
    step(5);
    end_of_test();
  end
  // Hang guard.
  initial begin
    #2000000;
    failures++;
    end_of_test();
  end
endmodule : debug_wire_autobaud_link_tb_top
bind debug_wire_autobaud_link debug_wire_autobaud_link_properties #(
  .BIT_P(8)) props_i (
  .clk_i(clk_i), .arst_n_i(arst_n_i),
  .debug_line_pin_o(debug_line_pin_o),
  .debug_line_pin_oe_o(debug_line_pin_oe_o),
  .rx_valid_o(rx_valid_o), .rx_frame_err_o(rx_frame_err_o),
  .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o),
  .rate_locked_o(rate_locked_o));

// ==== debug_wire_pkg.sv ====
// Shared constants for the single-wire debug link with rate detection.
package debug_wire_pkg;

  // System clock rate and period.
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;

  // Character framing: eight data bits, sent least significant first.
  localparam int unsigned DATA_BITS      = 8;
  localparam int unsigned BIT_IDX_W      = 3;
  localparam logic [2:0]  LAST_DATA_BIT  = 3'h7;

  // The sync character's low run is eight bit periods, so a shift of three.
  localparam int unsigned SYNC_LOW_BITS  = 8;
  localparam int unsigned SYNC_SHIFT     = 3;
  // After the low run, D7 and the stop bit are high: two bit periods.
  localparam logic [2:0]  SYNC_TAIL_BITS = 3'h2;

  // Width of the low-run counter and the shortest usable bit period.
  localparam int unsigned CNT_W          = 16;
  localparam int unsigned MIN_PERIOD     = 4;

  // Reset values.
  localparam logic        LINE_IDLE      = 1'b1;
  localparam logic [7:0]  DATA_RESET     = 8'h00;

endpackage : debug_wire_pkg

// ==== host_model.sv ====
// Debug host model that pulls the shared line low, open-drain.
`timescale 1ns/100ps
module host_model (
  // Clock
  input  wire logic clk_i,
  // Pull-down request on the wire
  output logic      pull_low_o
);
  initial pull_low_o = 1'b0;
  //////////////////////////////////////////////////////////////////////////
  // Framed, LSB first, stop released when stp is high and pulled low when it is low.
  // A high bit is only a release, so the device may take the line at once.
  task automatic send(input logic [7:0] b, input int p, input logic stp);
    logic [9:0] f;
    f = {stp, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      pull_low_o = ~f[i];
      repeat (p) @(posedge clk_i);
      #2;
    end
    pull_low_o = 1'b0;
  endtask : send
  // Short false start.
  // A pulse far shorter than half a bit must not pass for a start bit.
  task automatic pulse(input int n);
    pull_low_o = 1'b1;
    repeat (n) @(posedge clk_i);
    #2;
    pull_low_o = 1'b0;
  endtask : pulse
endmodule : host_model
